/* File: src/dsgsr_defines.vh */
/*
 * Register offsets, field positions, reset values and bus codes
 * of the deep-sleep gating and soft-reset block.
 * Assumes inclusion by bare name from the design files and the test bench.
 */
`ifndef DSGSR_DEFINES_VH
`define DSGSR_DEFINES_VH

`define DSGSR_ADDR_W 12
`define DSGSR_NPORT 8

// register offsets (byte addresses)
`define DSGSR_OFF_SRC0 12'h040
`define DSGSR_OFF_DSL 12'h128
`define DSGSR_OFF_SLP 12'h118
`define DSGSR_OFF_RUN 12'h108
`define DSGSR_OFF_RMC 12'h060
`define DSGSR_OFF_CAP1 12'h010
`define DSGSR_OFF_ISR 12'h180
`define DSGSR_OFF_IMR 12'h184

// field positions
`define DSGSR_AUTO_SEL_BIT 0
`define DSGSR_BUS0_RST_BIT 24
`define DSGSR_WDOG_RST_BIT 3
`define DSGSR_EV_FAULT 0
`define DSGSR_EV_DROP 1

// writable masks and reset values
`define DSGSR_SRC0_MASK 32'h0100_0008
`define DSGSR_RMC_MASK 32'h0000_0001
`define DSGSR_EV_MASK 32'h0000_0003
`define DSGSR_ZERO32 32'h0000_0000
`define DSGSR_CAP1_DEF 32'h0100_0008

// bus responses
`define DSGSR_RESP_OKAY 2'h0
`define DSGSR_RESP_SLVERR 2'h2

`endif

/* File: src/dsgsr_fault.v */
/*
 * Flags accesses aimed at ports whose clock is gated off.
 * Assumes port_access holds one strobe per port, one cycle per access.
 */
`include "dsgsr_defines.vh"

module dsgsr_fault #(
    parameter NPORT = `DSGSR_NPORT
)(
    // access strobes and current enables
    input wire [NPORT-1:0] port_access,
    input wire [NPORT-1:0] clk_en,
    // fault per port and summary
    output wire [NPORT-1:0] fault,
    output wire fault_any
);

    // R2 gated port faults
    assign fault = port_access & ~clk_en;
    assign fault_any = |fault;

endmodule // dsgsr_fault

/* File: src/dsgsr_gate_sel.v */
/*
 * Selects which gating word drives the port clock enables,
 * from the current power mode and the automatic-gating select.
 * Assumes mode inputs are synchronous levels; deep sleep outranks sleep.
 */
`include "dsgsr_defines.vh"

module dsgsr_gate_sel #(
    parameter NPORT = `DSGSR_NPORT
)(
    // gating words
    input wire [NPORT-1:0] run_gate,
    input wire [NPORT-1:0] sleep_gate,
    input wire [NPORT-1:0] deep_gate,
    // mode
    input wire auto_gating_select,
    input wire sleep_mode,
    input wire deep_sleep_mode,
    // result
    output reg [NPORT-1:0] gate_sel
);

    always @*
    begin
        // R5 sleep words need select
        if (!auto_gating_select)
            gate_sel = run_gate;
        // R4 mode picks word
        else if (deep_sleep_mode)
            gate_sel = deep_gate;
        else if (sleep_mode)
            gate_sel = sleep_gate;
        else
            gate_sel = run_gate;
    end

endmodule // dsgsr_gate_sel

/* File: src/dsgsr_top.v */
/*
 * Deep-sleep port clock gating and first soft-reset control,
 * with the companion gating words, mode select, capability word
 * and an event status/mask pair, behind an AXI4-Lite slave.
 * Assumes one clock, synchronous active-low reset, and that power
 * mode and port access strobes are synchronous to aclk.
 */
`include "dsgsr_defines.vh"

// Summary of operation
// R1: set bit clocks port, clear disables
// R2: access to gated port gives fault
// R3: deep-sleep gating word resets to zero
// R4: mode picks run, sleep or deep word
// R5: sleep words act only with select
// R6: bits 7..0 gate ports H..A
// R7: bits 31:8 read zero, ignore writes
// R8: software preserves reserved bits on writes
// R9: software enables ports before use
// R10: capability word masks reset writes
// R11: bit 24 resets bus controller zero
// R12: bit 3 resets watchdog, rest zero
// R13: set bit holds unit in reset
module dsgsr_top #(
    parameter NPORT = `DSGSR_NPORT,
    parameter [31:0] CAP_ONE = `DSGSR_CAP1_DEF
)(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // write address
    input wire [`DSGSR_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // read address
    input wire [`DSGSR_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // power mode
    input wire sleep_mode,
    input wire deep_sleep_mode,
    // port access side
    input wire [NPORT-1:0] port_access,
    output reg [NPORT-1:0] port_clk_en,
    output reg [NPORT-1:0] port_fault,
    // unit resets
    output reg bus_controller_zero_reset,
    output reg watchdog_reset_control,
    // interrupt
    output reg irq
);

    // byte-enable merge, used by every writable register
    function [31:0] merge_strb;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0] strb;
        integer i;
        begin
            merge_strb = old_val;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge_strb[i*8 +: 8] = new_val[i*8 +: 8];
        end
    endfunction

    // word-address match, low two bits ignored
    function addr_hit;
        input [`DSGSR_ADDR_W-1:0] a;
        input [`DSGSR_ADDR_W-1:0] off;
        begin
            addr_hit = (a[`DSGSR_ADDR_W-1:2] == off[`DSGSR_ADDR_W-1:2]);
        end
    endfunction

    function mapped;
        input [`DSGSR_ADDR_W-1:0] a;
        begin
            mapped = addr_hit(a, `DSGSR_OFF_SRC0) | addr_hit(a, `DSGSR_OFF_DSL)
                | addr_hit(a, `DSGSR_OFF_SLP) | addr_hit(a, `DSGSR_OFF_RUN)
                | addr_hit(a, `DSGSR_OFF_RMC) | addr_hit(a, `DSGSR_OFF_CAP1)
                | addr_hit(a, `DSGSR_OFF_ISR) | addr_hit(a, `DSGSR_OFF_IMR);
        end
    endfunction

    // write channel holding state
    reg aw_held_reg;
    reg w_held_reg;
    reg [`DSGSR_ADDR_W-1:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0] wstrb_reg;

    // register file
    reg [31:0] src0_reg;
    reg [NPORT-1:0] deep_gate_reg;
    reg [NPORT-1:0] sleep_gate_reg;
    reg [NPORT-1:0] run_gate_reg;
    reg [31:0] rmc_reg;
    reg [31:0] isr_reg;
    reg [31:0] imr_reg;

    reg [31:0] src0_next;
    reg [31:0] isr_next;
    reg [31:0] rd_word;
    reg drop_ev;

    wire wr_fire;
    wire rd_fire;
    wire [NPORT-1:0] gate_sel;
    wire [NPORT-1:0] fault_vec;
    wire fault_any;
    wire [31:0] wr_src0;
    wire [31:0] wr_deep;
    wire [31:0] wr_sleep;
    wire [31:0] wr_run;

    // a write completes once both halves are in and no response waits
    assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign rd_fire = s_axi_arvalid & s_axi_arready;

    // write address / data / response
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= {`DSGSR_ADDR_W{1'b0}};
            wdata_reg <= `DSGSR_ZERO32;
            wstrb_reg <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DSGSR_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_reg) ? `DSGSR_RESP_OKAY
                    : `DSGSR_RESP_SLVERR;
            end
            // both channels reopen only after the response is taken
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    assign wr_src0 = merge_strb(src0_reg, wdata_reg, wstrb_reg);
    assign wr_deep = merge_strb({{(32-NPORT){1'b0}}, deep_gate_reg}, wdata_reg, wstrb_reg);
    assign wr_sleep = merge_strb({{(32-NPORT){1'b0}}, sleep_gate_reg}, wdata_reg, wstrb_reg);
    assign wr_run = merge_strb({{(32-NPORT){1'b0}}, run_gate_reg}, wdata_reg, wstrb_reg);

    always @*
    begin
        src0_next = src0_reg;
        drop_ev = 1'b0;
        if (wr_fire && addr_hit(awaddr_reg, `DSGSR_OFF_SRC0))
        begin
            // R10 capability masks write
            src0_next = (src0_reg & ~CAP_ONE) | (wr_src0 & CAP_ONE);
            // R12 reserved bits zero
            src0_next = src0_next & `DSGSR_SRC0_MASK;
            drop_ev = |((wr_src0 ^ src0_reg) & ~CAP_ONE);
        end
    end

    // register writes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src0_reg <= `DSGSR_ZERO32;
            // R3 gating resets to zero
            deep_gate_reg <= {NPORT{1'b0}};
            sleep_gate_reg <= {NPORT{1'b0}};
            run_gate_reg <= {NPORT{1'b0}};
            rmc_reg <= `DSGSR_ZERO32;
            imr_reg <= `DSGSR_ZERO32;
        end
        else
        begin
            src0_reg <= src0_next;
            if (wr_fire)
            begin
                // R6 low bits per port
                if (addr_hit(awaddr_reg, `DSGSR_OFF_DSL))
                    deep_gate_reg <= wr_deep[NPORT-1:0];
                if (addr_hit(awaddr_reg, `DSGSR_OFF_SLP))
                    sleep_gate_reg <= wr_sleep[NPORT-1:0];
                if (addr_hit(awaddr_reg, `DSGSR_OFF_RUN))
                    run_gate_reg <= wr_run[NPORT-1:0];
                if (addr_hit(awaddr_reg, `DSGSR_OFF_RMC))
                    rmc_reg <= merge_strb(rmc_reg, wdata_reg, wstrb_reg)
                        & `DSGSR_RMC_MASK;
                if (addr_hit(awaddr_reg, `DSGSR_OFF_IMR))
                    imr_reg <= merge_strb(imr_reg, wdata_reg, wstrb_reg)
                        & `DSGSR_EV_MASK;
            end
        end
    end

    // read mux; unused high bits of narrow words read as zero
    always @*
    begin
        rd_word = `DSGSR_ZERO32;
        // R7 upper bits zero
        if (addr_hit(s_axi_araddr, `DSGSR_OFF_DSL))
            rd_word = {{(32-NPORT){1'b0}}, deep_gate_reg};
        else if (addr_hit(s_axi_araddr, `DSGSR_OFF_SLP))
            rd_word = {{(32-NPORT){1'b0}}, sleep_gate_reg};
        else if (addr_hit(s_axi_araddr, `DSGSR_OFF_RUN))
            rd_word = {{(32-NPORT){1'b0}}, run_gate_reg};
        else if (addr_hit(s_axi_araddr, `DSGSR_OFF_SRC0))
            rd_word = src0_reg;
        else if (addr_hit(s_axi_araddr, `DSGSR_OFF_RMC))
            rd_word = rmc_reg;
        else if (addr_hit(s_axi_araddr, `DSGSR_OFF_CAP1))
            rd_word = CAP_ONE;
        else if (addr_hit(s_axi_araddr, `DSGSR_OFF_ISR))
            rd_word = isr_reg;
        else if (addr_hit(s_axi_araddr, `DSGSR_OFF_IMR))
            rd_word = imr_reg;
    end

    // read address / data
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `DSGSR_ZERO32;
            s_axi_rresp <= `DSGSR_RESP_OKAY;
        end
        else
        begin
            if (rd_fire)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= mapped(s_axi_araddr) ? `DSGSR_RESP_OKAY
                    : `DSGSR_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // status: read clears, but a new event in that cycle survives
    always @*
    begin
        isr_next = isr_reg;
        if (rd_fire && addr_hit(s_axi_araddr, `DSGSR_OFF_ISR))
            isr_next = `DSGSR_ZERO32;
        if (fault_any)
            isr_next[`DSGSR_EV_FAULT] = 1'b1;
        if (drop_ev)
            isr_next[`DSGSR_EV_DROP] = 1'b1;
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            isr_reg <= `DSGSR_ZERO32;
            irq <= 1'b0;
        end
        else
        begin
            isr_reg <= isr_next;
            irq <= |(isr_next & imr_reg);
        end
    end

    dsgsr_gate_sel #(
        .NPORT(NPORT)
    ) u_gate_sel (
        .run_gate(run_gate_reg),
        .sleep_gate(sleep_gate_reg),
        .deep_gate(deep_gate_reg),
        .auto_gating_select(rmc_reg[`DSGSR_AUTO_SEL_BIT]),
        .sleep_mode(sleep_mode),
        .deep_sleep_mode(deep_sleep_mode),
        .gate_sel(gate_sel)
    );

    // faults judged against the enables the ports see now
    dsgsr_fault #(
        .NPORT(NPORT)
    ) u_fault (
        .port_access(port_access),
        .clk_en(port_clk_en),
        .fault(fault_vec),
        .fault_any(fault_any)
    );

    // port enables and unit resets
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_clk_en <= {NPORT{1'b0}};
            port_fault <= {NPORT{1'b0}};
            bus_controller_zero_reset <= 1'b0;
            watchdog_reset_control <= 1'b0;
        end
        else
        begin
            // R1 enable follows bit
            port_clk_en <= gate_sel;
            // R2 fault pulse out
            port_fault <= fault_vec;
            // R11 bus controller reset
            bus_controller_zero_reset <= src0_reg[`DSGSR_BUS0_RST_BIT];
            // R13 held while set
            watchdog_reset_control <= src0_reg[`DSGSR_WDOG_RST_BIT];
        end
    end

endmodule // dsgsr_top

/* File: tb/dsgsr_top_asserts.sv */
/* Port-level checker of the gating and soft-reset block.
   Assumes a bind onto dsgsr_top and a single clock domain. */
module dsgsr_top_asserts #(
    parameter NPORT = 8,
    parameter [31:0] CAP_ONE = 32'h0100_0008
)(
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // bus
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [11:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0] s_axi_rresp,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    // ports and modes
    input logic sleep_mode,
    input logic deep_sleep_mode,
    input logic [NPORT-1:0] port_access,
    input logic [NPORT-1:0] port_clk_en,
    input logic [NPORT-1:0] port_fault,
    input logic bus_controller_zero_reset,
    input logic watchdog_reset_control
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] ar_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // read data is judged against the address taken, not the live bus
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ar_q <= 12'h000;
        else if (s_axi_arvalid && s_axi_arready)
            ar_q <= s_axi_araddr;
    end
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_bad_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h3FC;
    endsequence
    sequence s_write_landed;
        $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
    endsequence
    property p_fault;
        port_fault == ($past(port_access) & ~$past(port_clk_en));
    endproperty
    property p_write_answer;
        s_both_taken |-> ##2 s_axi_bvalid;
    endproperty
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_bad_read;
        s_bad_read |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000;
    endproperty
    property p_gate_upper;
        s_axi_rvalid && ar_q == 12'h128 |-> s_axi_rdata[31:8] == 24'h00_0000;
    endproperty
    property p_src_bits;
        s_axi_rvalid && ar_q == 12'h040 |->
            (s_axi_rdata & ~(CAP_ONE & 32'h0100_0008)) == 32'h0000_0000;
    endproperty
    property p_unit_follows;
        $changed(watchdog_reset_control) || $changed(bus_controller_zero_reset)
            |-> s_write_landed;
    endproperty
    property p_en_cause;
        $changed(port_clk_en) |-> s_write_landed or
            ($past(sleep_mode) != $past(sleep_mode, 2)) or
            ($past(deep_sleep_mode) != $past(deep_sleep_mode, 2));
    endproperty
    a_fault: assert property (p_fault) else $error("fault pulse wrong");
    a_write_answer: assert property (p_write_answer) else $error("no write answer");
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    a_bad_read: assert property (p_bad_read) else $error("unmapped read answer");
    a_gate_upper: assert property (p_gate_upper) else $error("gate upper bits set");
    a_src_bits: assert property (p_src_bits) else $error("reset word bit set");
    a_unit_follows: assert property (p_unit_follows) else $error("unit reset moved");
    a_en_cause: assert property (p_en_cause) else $error("enable moved");
endmodule // dsgsr_top_asserts

bind dsgsr_top dsgsr_top_asserts #(.NPORT(NPORT), .CAP_ONE(CAP_ONE)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode), .port_access(port_access),
    .port_clk_en(port_clk_en), .port_fault(port_fault),
    .bus_controller_zero_reset(bus_controller_zero_reset),
    .watchdog_reset_control(watchdog_reset_control));

/* File: tb/test_deep_sleep_gate_and_soft_reset.sv */
/* Self-checking bench of the gating and soft-reset block.
   Assumes dsgsr_top with default parameters and its defines header. */
`include "dsgsr_defines.vh"
module test_deep_sleep_gate_and_soft_reset;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, v;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic sleep_mode = 1'b0, deep_sleep_mode = 1'b0;
    logic [7:0] port_access = 8'h00, port_clk_en, port_fault;
    logic bus_controller_zero_reset, watchdog_reset_control;
    logic [31:0] lfsr = 32'h6622;
    int fails = 0, checks = 0;
    dsgsr_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sleep_mode(sleep_mode),
        .deep_sleep_mode(deep_sleep_mode), .port_access(port_access),
        .port_clk_en(port_clk_en), .port_fault(port_fault),
        .bus_controller_zero_reset(bus_controller_zero_reset),
        .watchdog_reset_control(watchdog_reset_control), .irq(irq));
    initial forever #12.5 aclk = ~aclk;
    function automatic logic [31:0] step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // deep sleep outranks sleep; without the select the run word rules
    function automatic logic [7:0] want_gate(input int k);
        if (!k[2])
            return 8'h0F;
        if (k[1])
            return 8'hC5;
        return k[0] ? 8'h30 : 8'h0F;
    endfunction
    task automatic chk_word(input logic [31:0] got, input logic [31:0] want);
        checks++;
        if (got !== want)
        begin
            fails++;
            $display("BAD %0t word %h expected %h", $time, got, want);
        end
    endtask
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] want);
        checks++;
        if (got !== want)
        begin
            fails++;
            $display("BAD %0t resp %h expected %h", $time, got, want);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // slow holds the response ready back until the answer shows
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= !slow;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && !s_axi_bready)
                s_axi_bready <= 1'b1;
        end
        while (!(s_axi_bvalid && s_axi_bready));
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= !slow;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && !s_axi_rready)
                s_axi_rready <= 1'b1;
        end
        while (!(s_axi_rvalid && s_axi_rready));
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    initial
    begin
        #500000;
        fails++;
        wrap_up;
    end
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`DSGSR_OFF_DSL);
        chk_word(rd, 32'h0);
        chk_resp(resp, `DSGSR_RESP_OKAY);
        axr(`DSGSR_OFF_SRC0);
        chk_word(rd, 32'h0);
        chk_word({24'h0, port_clk_en}, 32'h0);
        for (int i = 0; i < 6; i++)
        begin
            lfsr = step(lfsr);
            slow = lfsr[8];
            v = (i == 0) ? 32'hFFFF_FFFF : lfsr;
            axw(`DSGSR_OFF_DSL, v);
            axr(`DSGSR_OFF_DSL);
            chk_word(rd, {24'h0, v[7:0]});
        end
        // software read-modify-write hands reserved bits back as read
        axr(`DSGSR_OFF_DSL);
        axw(`DSGSR_OFF_DSL, rd ^ 32'h0000_0081);
        axr(`DSGSR_OFF_DSL);
        chk_word(rd, {24'h0, v[7:0] ^ 8'h81});
        slow = 1'b0;
        axw(`DSGSR_OFF_RUN, 32'h0F);
        axw(`DSGSR_OFF_SLP, 32'h30);
        axw(`DSGSR_OFF_DSL, 32'hC5);
        for (int k = 0; k < 8; k++)
        begin
            if (k == 4)
                axw(`DSGSR_OFF_RMC, 32'h1);
            @(posedge aclk);
            sleep_mode <= k[0];
            deep_sleep_mode <= k[1];
            repeat (2) @(posedge aclk);
            chk_word({24'h0, port_clk_en}, {24'h0, want_gate(k)});
        end
        axw(`DSGSR_OFF_IMR, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            lfsr = step(lfsr);
            v = (i == 0) ? 32'hFF : lfsr;
            @(posedge aclk);
            port_access <= v[7:0];
            @(posedge aclk);
            port_access <= 8'h00;
            @(posedge aclk);
            chk_word({24'h0, port_fault}, {24'h0, v[7:0] & 8'h3A});
        end
        chk_word({31'h0, irq}, 32'h0);
        axw(`DSGSR_OFF_IMR, 32'h3);
        repeat (2) @(posedge aclk);
        chk_word({31'h0, irq}, 32'h1);
        axr(`DSGSR_OFF_ISR);
        chk_word(rd, 32'h1);
        @(posedge aclk);
        chk_word({31'h0, irq}, 32'h0);
        axw(`DSGSR_OFF_SRC0, 32'hFFFF_FFFF);
        chk_resp(resp, `DSGSR_RESP_OKAY);
        axr(`DSGSR_OFF_CAP1);
        chk_word(rd, `DSGSR_CAP1_DEF);
        axr(`DSGSR_OFF_SRC0);
        chk_word(rd, `DSGSR_CAP1_DEF & `DSGSR_SRC0_MASK);
        chk_word({30'h0, bus_controller_zero_reset, watchdog_reset_control}, 32'h3);
        chk_word({31'h0, irq}, 32'h1);
        axr(`DSGSR_OFF_ISR);
        chk_word(rd, 32'h2);
        axw(`DSGSR_OFF_SRC0, 32'h8);
        axr(`DSGSR_OFF_SRC0);
        chk_word({30'h0, bus_controller_zero_reset, watchdog_reset_control}, 32'h1);
        axr(12'h3FC);
        chk_resp(resp, `DSGSR_RESP_SLVERR);
        chk_word(rd, 32'h0);
        axw(12'h3FC, 32'h1);
        chk_resp(resp, `DSGSR_RESP_SLVERR);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        axr(`DSGSR_OFF_DSL);
        chk_word(rd, 32'h0);
        chk_word({23'h0, watchdog_reset_control, port_clk_en}, 32'h0);
        wrap_up;
    end
endmodule // test_deep_sleep_gate_and_soft_reset
